// file: core/dcd_params.svh
`ifndef DCD_PARAMS_SVH
`define DCD_PARAMS_SVH

// Register indices; byte address is four times the index
`define DCD_IDX_DIV0_PERIOD 10'h190
`define DCD_IDX_DIV0_CTRL 10'h191
`define DCD_IDX_DIV0_ROUTE 10'h192
`define DCD_IDX_DIV1_PERIOD 10'h196
`define DCD_IDX_DIV1_CTRL 10'h197
`define DCD_IDX_DIV1_ROUTE 10'h198
`define DCD_IDX_SRC_SELECT 10'h1E1
`define DCD_IDX_STATUS 10'h1F0

// Field positions
`define DCD_BIT_BYPASS 7
`define DCD_BIT_NOSYNC 6
`define DCD_BIT_FORCE_HIGH 5
`define DCD_BIT_START_HIGH 4
`define DCD_BIT_DIRECT 1
`define DCD_BIT_DCC_OFF 0

// Reset values
`define DCD_RST_DIV0_CTRL 8'h80
`define DCD_RST_DIV1_CTRL 8'h00
`define DCD_RST_ZERO 8'h00

// Source select encodings
`define DCD_SRC_EXT 2'h0
`define DCD_SRC_OSC 2'h2

// Bus responses
`define DCD_RESP_OKAY 2'h0
`define DCD_RESP_SLVERR 2'h2

`endif

// file: core/dcd_pkg.sv
`default_nettype none

package dcd_pkg;
    typedef enum logic [2:0] {
        DCD_ST_BYP = 3'h1,
        DCD_ST_HOLD = 3'h2,
        DCD_ST_RUN = 3'h4
    } dcd_state_t;
endpackage : dcd_pkg

`default_nettype wire

// file: core/dcd_divider.sv
`default_nettype none

module dcd_divider (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] low_cnt,
    input wire logic [3:0] high_cnt,
    input wire logic [3:0] phase,
    input wire logic start_high,
    input wire logic bypass,
    input wire logic nosync,
    input wire logic force_high,
    input wire logic dcc_off,
    input wire logic sync_lvl,
    output logic div_out,
    output dcd_pkg::dcd_state_t state
);
    import dcd_pkg::*;

    dcd_state_t state_reg;
    dcd_state_t state_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic out_reg;
    logic out_next;
    logic sync_active;
    logic forced;

    // Cycles minus one for a segment at the given level
    function automatic logic [4:0] seg_len(
        input logic level,
        input logic [3:0] lo,
        input logic [3:0] hi,
        input logic dcc_off_i
    );
        logic [5:0] total;
        logic [4:0] hi_half;
        total = 6'(lo) + 6'(hi) + 6'h02;
        hi_half = total[5:1];
        if (dcc_off_i)
            seg_len = level ? {1'b0, hi} : {1'b0, lo};
        // Correction splits the period evenly; odd totals give the extra cycle to low
        else if (level)
            seg_len = hi_half - 5'h01;
        else
            seg_len = 5'(total - 6'(hi_half) - 6'h01);
    endfunction : seg_len

    always_comb
    begin
        sync_active = sync_lvl & ~nosync;
        forced = nosync & force_high;
        state_next = state_reg;
        cnt_next = cnt_reg;
        out_next = out_reg;
        case (state_reg)
            DCD_ST_BYP:
            begin
                out_next = ~out_reg;
                if (!bypass)
                begin
                    state_next = DCD_ST_HOLD;
                    cnt_next = {1'b0, phase};
                    out_next = start_high;
                end
            end
            DCD_ST_HOLD:
            begin
                out_next = start_high;
                if (sync_active)
                    cnt_next = {1'b0, phase};
                else if (cnt_reg == 5'h00)
                begin
                    state_next = DCD_ST_RUN;
                    cnt_next = seg_len(start_high, low_cnt, high_cnt, dcc_off);
                end
                else
                    cnt_next = cnt_reg - 5'h01;
            end
            DCD_ST_RUN:
            begin
                if (cnt_reg == 5'h00)
                begin
                    out_next = ~out_reg;
                    cnt_next = seg_len(~out_reg, low_cnt, high_cnt, dcc_off);
                end
                else
                    cnt_next = cnt_reg - 5'h01;
            end
            default:
            begin
                state_next = DCD_ST_HOLD;
                cnt_next = {1'b0, phase};
            end
        endcase
        if (bypass)
        begin
            if (state_reg != DCD_ST_BYP)
                state_next = DCD_ST_BYP;
        end
        else if (forced)
        begin
            out_next = 1'b1;
            state_next = DCD_ST_HOLD;
            cnt_next = {1'b0, phase};
        end
        else if (sync_active && state_reg != DCD_ST_HOLD)
        begin
            state_next = DCD_ST_HOLD;
            cnt_next = {1'b0, phase};
            out_next = start_high;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= DCD_ST_BYP;
            cnt_reg <= 5'h00;
            out_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            out_reg <= out_next;
        end
    end

    assign div_out = out_reg;
    assign state = state_reg;

    AST_BYPASS_TOGGLES: assert property (@(posedge aclk) disable iff (!aresetn)
        (aresetn && state_reg == DCD_ST_BYP && bypass) [*2] |-> out_reg != $past(out_reg))
        else $error("bypassed divider did not follow its input");

    AST_FORCE_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
        (forced && !bypass) [*2] |-> out_reg && state_reg == DCD_ST_HOLD)
        else $error("forced divider output not high");

    AST_SYNC_HOLDS_START: assert property (@(posedge aclk) disable iff (!aresetn)
        (sync_active && !bypass && !forced) |=> out_reg == $past(start_high) && state_reg == DCD_ST_HOLD)
        else $error("obeyed sync did not hold start level");

    AST_NOSYNC_IGNORES: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == DCD_ST_RUN && nosync && !force_high && !bypass && cnt_reg != 5'h00)
        |=> state_reg == DCD_ST_RUN)
        else $error("divider restarted although sync is ignored");

    AST_LOW_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == DCD_ST_RUN && cnt_reg == 5'h00 && out_reg && dcc_off && !bypass && !forced && !sync_active)
        |=> !out_reg && cnt_reg == {1'b0, $past(low_cnt)})
        else $error("low segment length wrong");

    AST_HIGH_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == DCD_ST_RUN && cnt_reg == 5'h00 && !out_reg && dcc_off && !bypass && !forced && !sync_active)
        |=> out_reg && cnt_reg == {1'b0, $past(high_cnt)})
        else $error("high segment length wrong");

    AST_PHASE_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
        (sync_active && !bypass && !forced) |=> cnt_reg == {1'b0, $past(phase)})
        else $error("phase offset not loaded on sync");

endmodule : dcd_divider

`default_nettype wire

// file: core/dcd_top.sv
// The implementer's own choice: register access over AXI4-Lite.
`include "dcd_params.svh"
`default_nettype none

module dcd_top #(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic osc_in,
    input wire logic ext_clk_in,
    input wire logic chip_sync,
    output logic pair0_output_a,
    output logic pair0_output_b,
    output logic pair1_output_a,
    output logic pair1_output_b,
    output dcd_pkg::dcd_state_t div0_state,
    output dcd_pkg::dcd_state_t div1_state
);
    import dcd_pkg::*;

    logic [7:0] div0_period_counts_reg, div0_period_counts_next;
    logic [7:0] div0_control_phase_reg, div0_control_phase_next;
    logic [7:0] div0_route_dutycycle_reg, div0_route_dutycycle_next;
    logic [7:0] div1_period_counts_reg, div1_period_counts_next;
    logic [7:0] div1_control_phase_reg, div1_control_phase_next;
    logic [7:0] div1_route_dutycycle_reg, div1_route_dutycycle_next;
    logic [7:0] src_select_reg, src_select_next;

    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;

    // Pin synchronisers: first stage feeds only the second
    logic [2:0] pin_meta_reg, pin_meta_next;
    logic [2:0] pin_sync_reg, pin_sync_next;

    logic p0a_reg, p0a_next;
    logic p0b_reg, p0b_next;
    logic p1a_reg, p1a_next;
    logic p1b_reg, p1b_next;

    logic div0_out;
    logic div1_out;
    dcd_state_t div0_st;
    dcd_state_t div1_st;
    dcd_state_t div0_st_reg;
    dcd_state_t div1_st_reg;
    logic osc_s;
    logic ext_s;
    logic sync_s;
    logic wr_hs;
    logic rd_hs;
    logic [9:0] wr_idx;
    logic [9:0] rd_idx;

    function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] addr);
        reg_index = 10'(addr[ADDR_W-1:2]);
    endfunction : reg_index

    // Pair source: divider or one of the raw clocks
    function automatic logic pair_source(
        input logic direct,
        input logic [1:0] sel,
        input logic osc,
        input logic ext,
        input logic div
    );
        if (direct && sel == `DCD_SRC_OSC)
            pair_source = osc;
        else if (direct && sel == `DCD_SRC_EXT)
            pair_source = ext;
        else
            pair_source = div;
    endfunction : pair_source

    assign osc_s = pin_sync_reg[0];
    assign ext_s = pin_sync_reg[1];
    assign sync_s = pin_sync_reg[2];
    assign wr_hs = awready_reg & awvalid & wvalid;
    assign rd_hs = arready_reg & arvalid;
    assign wr_idx = reg_index(awaddr);
    assign rd_idx = reg_index(araddr);

    dcd_divider u_div0 (
        .aclk(aclk),
        .aresetn(aresetn),
        .low_cnt(div0_period_counts_reg[7:4]),
        .high_cnt(div0_period_counts_reg[3:0]),
        .phase(div0_control_phase_reg[3:0]),
        .start_high(div0_control_phase_reg[`DCD_BIT_START_HIGH]),
        .bypass(div0_control_phase_reg[`DCD_BIT_BYPASS]),
        .nosync(div0_control_phase_reg[`DCD_BIT_NOSYNC]),
        .force_high(div0_control_phase_reg[`DCD_BIT_FORCE_HIGH]),
        .dcc_off(div0_route_dutycycle_reg[`DCD_BIT_DCC_OFF]),
        .sync_lvl(sync_s),
        .div_out(div0_out),
        .state(div0_st)
    );

    dcd_divider u_div1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .low_cnt(div1_period_counts_reg[7:4]),
        .high_cnt(div1_period_counts_reg[3:0]),
        .phase(div1_control_phase_reg[3:0]),
        .start_high(div1_control_phase_reg[`DCD_BIT_START_HIGH]),
        .bypass(div1_control_phase_reg[`DCD_BIT_BYPASS]),
        .nosync(div1_control_phase_reg[`DCD_BIT_NOSYNC]),
        .force_high(div1_control_phase_reg[`DCD_BIT_FORCE_HIGH]),
        .dcc_off(div1_route_dutycycle_reg[`DCD_BIT_DCC_OFF]),
        .sync_lvl(sync_s),
        .div_out(div1_out),
        .state(div1_st)
    );

    always_comb
    begin
        pin_meta_next = {chip_sync, ext_clk_in, osc_in};
        pin_sync_next = pin_meta_reg;
        p0a_next = pair_source(div0_route_dutycycle_reg[`DCD_BIT_DIRECT], src_select_reg[1:0], osc_s, ext_s,
                               div0_out);
        p0b_next = ~p0a_next;
        p1a_next = pair_source(div1_route_dutycycle_reg[`DCD_BIT_DIRECT], src_select_reg[1:0], osc_s, ext_s,
                               div1_out);
        p1b_next = ~p1a_next;
    end

    always_comb
    begin
        div0_period_counts_next = div0_period_counts_reg;
        div0_control_phase_next = div0_control_phase_reg;
        div0_route_dutycycle_next = div0_route_dutycycle_reg;
        div1_period_counts_next = div1_period_counts_reg;
        div1_control_phase_next = div1_control_phase_reg;
        div1_route_dutycycle_next = div1_route_dutycycle_reg;
        src_select_next = src_select_reg;
        // Address and data are taken on the same edge, one write at a time
        awready_next = awvalid & wvalid & ~awready_reg & ~bvalid_reg;
        wready_next = awvalid & wvalid & ~awready_reg & ~bvalid_reg;
        bvalid_next = bvalid_reg & ~bready;
        bresp_next = bresp_reg;
        if (wr_hs)
        begin
            bvalid_next = 1'b1;
            bresp_next = `DCD_RESP_OKAY;
            case (wr_idx)
                `DCD_IDX_DIV0_PERIOD:
                    if (wstrb[0]) div0_period_counts_next = wdata[7:0];
                `DCD_IDX_DIV0_CTRL:
                    if (wstrb[0]) div0_control_phase_next = wdata[7:0];
                `DCD_IDX_DIV0_ROUTE:
                    if (wstrb[0]) div0_route_dutycycle_next = {6'h00, wdata[1:0]};
                `DCD_IDX_DIV1_PERIOD:
                    if (wstrb[0]) div1_period_counts_next = wdata[7:0];
                `DCD_IDX_DIV1_CTRL:
                    if (wstrb[0]) div1_control_phase_next = wdata[7:0];
                `DCD_IDX_DIV1_ROUTE:
                    if (wstrb[0]) div1_route_dutycycle_next = {6'h00, wdata[1:0]};
                `DCD_IDX_SRC_SELECT:
                    if (wstrb[0]) src_select_next = {6'h00, wdata[1:0]};
                default:
                    bresp_next = `DCD_RESP_SLVERR;
            endcase
        end
    end

    always_comb
    begin
        arready_next = arvalid & ~arready_reg & ~rvalid_reg;
        rvalid_next = rvalid_reg & ~rready;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (rd_hs)
        begin
            rvalid_next = 1'b1;
            rresp_next = `DCD_RESP_OKAY;
            case (rd_idx)
                `DCD_IDX_DIV0_PERIOD: rdata_next = {24'h000000, div0_period_counts_reg};
                `DCD_IDX_DIV0_CTRL: rdata_next = {24'h000000, div0_control_phase_reg};
                `DCD_IDX_DIV0_ROUTE: rdata_next = {24'h000000, div0_route_dutycycle_reg};
                `DCD_IDX_DIV1_PERIOD: rdata_next = {24'h000000, div1_period_counts_reg};
                `DCD_IDX_DIV1_CTRL: rdata_next = {24'h000000, div1_control_phase_reg};
                `DCD_IDX_DIV1_ROUTE: rdata_next = {24'h000000, div1_route_dutycycle_reg};
                `DCD_IDX_SRC_SELECT: rdata_next = {24'h000000, src_select_reg};
                `DCD_IDX_STATUS: rdata_next = {24'h000000, div1_out, div0_out, div1_st, div0_st};
                default:
                begin
                    rdata_next = 32'h00000000;
                    rresp_next = `DCD_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div0_period_counts_reg <= `DCD_RST_ZERO;
            // divider 0 bypassed, divider 1 dividing
            div0_control_phase_reg <= `DCD_RST_DIV0_CTRL;
            div0_route_dutycycle_reg <= `DCD_RST_ZERO;
            div1_period_counts_reg <= `DCD_RST_ZERO;
            div1_control_phase_reg <= `DCD_RST_DIV1_CTRL;
            div1_route_dutycycle_reg <= `DCD_RST_ZERO;
            src_select_reg <= `DCD_RST_ZERO;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= 2'h0;
            rdata_reg <= 32'h00000000;
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
            p0a_reg <= 1'b0;
            p0b_reg <= 1'b1;
            p1a_reg <= 1'b0;
            p1b_reg <= 1'b1;
            div0_st_reg <= DCD_ST_BYP;
            div1_st_reg <= DCD_ST_BYP;
        end
        else
        begin
            div0_period_counts_reg <= div0_period_counts_next;
            div0_control_phase_reg <= div0_control_phase_next;
            div0_route_dutycycle_reg <= div0_route_dutycycle_next;
            div1_period_counts_reg <= div1_period_counts_next;
            div1_control_phase_reg <= div1_control_phase_next;
            div1_route_dutycycle_reg <= div1_route_dutycycle_next;
            src_select_reg <= src_select_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            pin_meta_reg <= pin_meta_next;
            pin_sync_reg <= pin_sync_next;
            p0a_reg <= p0a_next;
            p0b_reg <= p0b_next;
            p1a_reg <= p1a_next;
            p1b_reg <= p1b_next;
            div0_st_reg <= div0_st;
            div1_st_reg <= div1_st;
        end
    end

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;
    assign pair0_output_a = p0a_reg;
    assign pair0_output_b = p0b_reg;
    assign pair1_output_a = p1a_reg;
    assign pair1_output_b = p1b_reg;
    assign div0_state = div0_st_reg;
    assign div1_state = div1_st_reg;

    AST_RESET_DEFAULTS: assert property (@(posedge aclk)
        $past(!aresetn) |-> div0_control_phase_reg[`DCD_BIT_BYPASS] && !div1_control_phase_reg[`DCD_BIT_BYPASS])
        else $error("bypass defaults wrong after reset");

    AST_DIRECT_OSC: assert property (@(posedge aclk) disable iff (!aresetn)
        (div0_route_dutycycle_reg[`DCD_BIT_DIRECT] && src_select_reg[1:0] == `DCD_SRC_OSC)
        |=> pair0_output_a == $past(osc_s) && pair0_output_b == !$past(osc_s))
        else $error("oscillator not routed to pair 0");

    AST_DIRECT_NO_EFFECT: assert property (@(posedge aclk) disable iff (!aresetn)
        (div1_route_dutycycle_reg[`DCD_BIT_DIRECT] && src_select_reg[1:0] == 2'h1)
        |=> pair1_output_a == $past(div1_out))
        else $error("select 01b changed pair 1 routing");

    AST_PAIR0_FROM_DIV: assert property (@(posedge aclk) disable iff (!aresetn)
        !div0_route_dutycycle_reg[`DCD_BIT_DIRECT] |=> pair0_output_a == $past(div0_out))
        else $error("pair 0 not fed by divider 0");

    AST_WRITE_RESPONSE: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_hs |=> bvalid_reg && !awready_reg && !wready_reg)
        else $error("write not answered one cycle after handshake");

endmodule : dcd_top

`default_nettype wire

// file: tb/tb_top.sv
`include "dcd_params.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dcd_pkg::*;

    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, osc_in, ext_clk_in, chip_sync;
    logic awready, wready, bvalid, arready, rvalid, p0a, p0b, p1a, p1b;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    dcd_state_t div0_state, div1_state;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int hi, lo, n;

    dcd_top dcd_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .osc_in(osc_in), .ext_clk_in(ext_clk_in), .chip_sync(chip_sync),
        .pair0_output_a(p0a), .pair0_output_b(p0b), .pair1_output_a(p1a), .pair1_output_b(p1b),
        .div0_state(div0_state), .div1_state(div1_state));

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Whole run needs well under a thousand cycles; generous margin
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            $display("timeout after %0d cycles", cyc);
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    function automatic logic [11:0] ba(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction : ba

    task automatic wr(input logic [9:0] idx, input logic [7:0] v, output logic [1:0] resp);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= ba(idx);
        wdata <= {24'h000000, v};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (awready === 1'b1 && !aw_done)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w_done)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd

    function automatic logic lvl(input bit s);
        return s ? p1a : p0a;
    endfunction : lvl

    // Skip two periods so a config change mid-period cannot distort the run lengths
    task automatic meas(input bit s, output int h, output int l);
        repeat (2)
        begin
            do @(posedge aclk); while (lvl(s) !== 1'b0);
            do @(posedge aclk); while (lvl(s) !== 1'b1);
        end
        h = 0;
        l = 0;
        while (lvl(s) === 1'b1)
        begin
            h++;
            @(posedge aclk);
        end
        while (lvl(s) === 1'b0)
        begin
            l++;
            @(posedge aclk);
        end
    endtask : meas

    task automatic steady(input bit s, input logic v);
        int k;
        k = 0;
        repeat (8) @(posedge aclk);
        repeat (20)
        begin
            @(posedge aclk);
            k += (lvl(s) === v) ? 1 : 0;
        end
        chk("steady level", k, 20);
    endtask : steady

    task automatic t_reset();
        rd(ba(`DCD_IDX_DIV0_CTRL), d, r);
        chk("div0 ctrl", d, 32'h00000080);
        rd(ba(`DCD_IDX_DIV1_CTRL), d, r);
        chk("div1 ctrl", d, 32'h00000000);
        rd(ba(`DCD_IDX_DIV0_PERIOD), d, r);
        chk("div0 period", d, 32'h00000000);
        chk("div0 state", {29'h0, div0_state}, {29'h0, DCD_ST_BYP});
        rd(12'h100, d, r);
        chk("unmapped resp", {30'h0, r}, {30'h0, `DCD_RESP_SLVERR});
        wr(`DCD_IDX_STATUS, 8'hFF, r);
        chk("status write resp", {30'h0, r}, {30'h0, `DCD_RESP_SLVERR});
        $display("test reset done");
    endtask : t_reset

    task automatic t_div0();
        wr(`DCD_IDX_DIV0_PERIOD, 8'h24, r);
        wr(`DCD_IDX_DIV0_ROUTE, 8'h01, r);
        meas(1'b0, hi, lo);
        chk("bypass high", hi, 1);
        chk("bypass low", lo, 1);
        wr(`DCD_IDX_DIV0_CTRL, 8'h00, r);
        meas(1'b0, hi, lo);
        chk("div0 high", hi, 5);
        chk("div0 low", lo, 3);
        $display("test div0 done");
    endtask : t_div0

    task automatic t_div1();
        logic [7:0] per [2] = '{8'h24, 8'hF0};
        int eh [4] = '{5, 3, 1, 16};
        int dh [4] = '{4, 4, 8, 9};
        for (int i = 0; i < 2; i++)
        begin
            wr(`DCD_IDX_DIV1_PERIOD, per[i], r);
            wr(`DCD_IDX_DIV1_ROUTE, 8'h01, r);
            meas(1'b1, hi, lo);
            chk("div1 high", hi, eh[2*i]);
            chk("div1 low", lo, eh[2*i+1]);
            chk("pair1 complement", p1b, {31'h0, ~p1a});
            wr(`DCD_IDX_DIV1_ROUTE, 8'h00, r);
            meas(1'b1, hi, lo);
            chk("dcc high", hi, dh[2*i]);
            chk("dcc low", lo, dh[2*i+1]);
        end
        $display("test div1 done");
    endtask : t_div1

    task automatic t_sync();
        wr(`DCD_IDX_DIV1_PERIOD, 8'h24, r);
        wr(`DCD_IDX_DIV1_ROUTE, 8'h01, r);
        chip_sync <= 1'b1;
        steady(1'b1, 1'b0);
        chk("held state", {29'h0, div1_state}, {29'h0, DCD_ST_HOLD});
        wr(`DCD_IDX_DIV1_CTRL, 8'h10, r);
        steady(1'b1, 1'b1);
        wr(`DCD_IDX_DIV1_CTRL, 8'h60, r);
        steady(1'b1, 1'b1);
        wr(`DCD_IDX_DIV1_CTRL, 8'h40, r);
        meas(1'b1, hi, lo);
        chk("nosync high", hi, 5);
        chk("nosync low", lo, 3);
        wr(`DCD_IDX_DIV1_CTRL, 8'h05, r);
        steady(1'b1, 1'b0);
        chip_sync <= 1'b0;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (p1a !== 1'b1);
        // Two sync flops, phase 5 plus one, low 2 plus one, pair flop and sampling edge
        chk("phase delay", n, 2 + 6 + 3 + 2);
        wr(`DCD_IDX_DIV1_CTRL, 8'h00, r);
        $display("test sync done");
    endtask : t_sync

    task automatic t_route();
        osc_in <= 1'b1;
        wr(`DCD_IDX_SRC_SELECT, 8'h02, r);
        wr(`DCD_IDX_DIV1_ROUTE, 8'h02, r);
        steady(1'b1, 1'b1);
        wr(`DCD_IDX_DIV0_ROUTE, 8'h02, r);
        steady(1'b0, 1'b1);
        chk("pair0 b", p0b, 32'h00000000);
        wr(`DCD_IDX_SRC_SELECT, 8'h00, r);
        steady(1'b1, 1'b0);
        wr(`DCD_IDX_SRC_SELECT, 8'h01, r);
        meas(1'b1, hi, lo);
        chk("sel01 high", hi, 4);
        chk("sel01 low", lo, 4);
        wr(`DCD_IDX_SRC_SELECT, 8'h02, r);
        wr(`DCD_IDX_DIV0_ROUTE, 8'h00, r);
        meas(1'b0, hi, lo);
        chk("route off high", hi, 4);
        chk("route off low", lo, 4);
        $display("test route done");
    endtask : t_route

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, osc_in, ext_clk_in, chip_sync} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_div0();
        t_div1();
        t_sync();
        t_route();
        summarize();
    end
endmodule : tb_top

`default_nettype wire
